//--- rtl/iiep_params.svh
`ifndef IIEP_PARAMS_SVH
`define IIEP_PARAMS_SVH

// geometry
`define IIEP_NUM_PORTS     4
`define IIEP_LINES_PER_PORT 8
`define IIEP_LINES_PER_GROUP 4

// word index of each register slot (host address lines A1..A6)
`define IIEP_ADDR_W        6
`define IIEP_SLOT_PORT0    3'h0
`define IIEP_SLOT_DBCTL    3'h0
`define IIEP_SLOT_DBDUR    3'h1
`define IIEP_SLOT_DBCLK    3'h3
`define IIEP_SLOT_SUMMARY  3'h6
`define IIEP_SLOT_CTL      3'h7
`define IIEP_PAGE_PORTS    3'h0
`define IIEP_IRQEN_IDX     6'h08

// control register fields
`define IIEP_MASK_MSB      3
`define IIEP_BANK_LSB      6
`define IIEP_BANK_MSB      7
`define IIEP_SUM_ANY_BIT   7
`define IIEP_IRQEN_BIT     0

// bank codes
`define IIEP_BANK_INPUT    2'h0
`define IIEP_BANK_EVENT    2'h1
`define IIEP_BANK_DEBOUNCE 2'h2
`define IIEP_BANK_INVALID  2'h3

// unlock byte sequence
`define IIEP_UNLOCK_B0     8'h07
`define IIEP_UNLOCK_B1     8'h0D
`define IIEP_UNLOCK_B2     8'h06
`define IIEP_UNLOCK_B3     8'h12

// reset values
`define IIEP_PORT_RST      8'h00
`define IIEP_MASK_RST      4'h0
`define IIEP_BYTE_RST      8'h00

`endif

//--- rtl/iiep_pkg.sv
`default_nettype none
package iiep_pkg;

	// one host access as seen on the module bus pins
	typedef struct packed {
		logic       sel;
		logic       write;
		logic [5:0] addr;
		logic [7:0] wdata;
	} iiep_bus_req_t;

	// answer to the host: low byte only, upper byte never driven
	typedef struct packed {
		logic       ack;
		logic       oe;
		logic [7:0] rdata;
	} iiep_bus_rsp_t;

	// unlock tracker and operating mode, one-hot
	typedef enum logic [5:0] {
		UNL_WAIT0 = 6'h01,
		UNL_WAIT1 = 6'h02,
		UNL_WAIT2 = 6'h04,
		UNL_WAIT3 = 6'h08,
		MODE_ENH  = 6'h10,
		MODE_STD  = 6'h20
	} iiep_mode_t;

endpackage
`default_nettype wire

//--- rtl/iiep_event_line.sv
`default_nettype none
module iiep_event_line (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic lineIn,
	input  wire logic fallSense,
	input  wire logic wrStb,
	input  wire logic wrBit,
	output logic      eventFlag
);

	logic linePrev_q;
	logic armed_q;
	logic armed_d;
	logic flag_q;
	logic flag_d;

	// edge of the chosen polarity
	wire riseSeen = lineIn & ~linePrev_q;
	wire fallSeen = ~lineIn & linePrev_q;
	wire edgeSeen = fallSense ? fallSeen : riseSeen;
	wire clrReq   = wrStb & ~wrBit;

	// writing 0 disarms, writing 1 re-arms
	assign armed_d = wrStb ? wrBit : armed_q;
	// an edge in the clear cycle still sets the flag
	assign flag_d = (armed_q & edgeSeen) | (flag_q & ~clrReq);
	assign eventFlag = flag_q;

	// line history, arm and flag state
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			linePrev_q <= 1'b0;
			armed_q    <= 1'b0;
			flag_q     <= 1'b0;
		end else begin
			linePrev_q <= lineIn;
			armed_q    <= armed_d;
			flag_q     <= flag_d;
		end
	end

endmodule
`default_nettype wire

//--- rtl/iiep_input_ports.sv
// Function
// - only the low data byte is ever driven on reads; upper byte floats.
// - accesses to unused locations get no acknowledge and no data drive.
// - every access to a used location is acknowledged on the next clock, no wait states.
// - only ports 0 to 3 exist; ports 4 and 5 are unused, port 6 is used only in bank 1 (summary).
// - port read gives line states, lowest line of the port on bit 0.
// - a written 1 forces that input to read 0 until 0 written or reset.
// - reset clears all port data registers.
// - control bits 0-3 block bank 0 writes to ports 0-3 and read back.
// - write mask is clear after reset.
// - enhanced mode only after exact bytes 07,0D,06,12 to port 7 after reset.
// - in enhanced mode control bits 6-7 select and report the bank.
// - bank 00 inputs, 01 events, 10 debounce; 11 must not be written.
// - reset gives standard mode, clear mask and bank 0.
// - bank 1 port reads return the event flags of its eight lines.
// - bank 1 port write of 0 clears the line's event flag.
// - a cleared line stays disarmed until a 1 is written to re-arm it.
// - summary bits 0-3 give per-port events, bit 7 any event.
// - summary event can drive the interrupt line only when enabled.
// - polarity per group of four lines: 1 falling, 0 rising.
// - interrupt line driven only when enable bit 0 is set; resets clear.
`include "iiep_params.svh"
`default_nettype none
module iiep_input_ports #(
	parameter int NUM_PORTS = `IIEP_NUM_PORTS
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire iiep_pkg::iiep_bus_req_t busReq,
	output var  iiep_pkg::iiep_bus_rsp_t busRsp,
	input  wire logic [NUM_PORTS*8-1:0]  inputLines,
	output logic                         intReq0_n
);

	localparam int LPP   = `IIEP_LINES_PER_PORT;
	localparam int LINES = NUM_PORTS * LPP;
	localparam int LPG   = `IIEP_LINES_PER_GROUP;
	localparam int GROUPS = LINES / LPG;

	// access detection: one access per rising select
	logic selPrev_q;
	wire accStart = busReq.sel & ~selPrev_q;
	wire isWrite  = accStart & busReq.write;
	wire isRead   = accStart & ~busReq.write;

	// address split: page of eight slots and slot number
	wire [2:0] slot     = busReq.addr[2:0];
	wire       inPage   = busReq.addr[5:3] == `IIEP_PAGE_PORTS;
	wire       isIrqEn  = busReq.addr == `IIEP_IRQEN_IDX;
	wire       isData   = inPage & (slot <= 3'(NUM_PORTS - 1));
	wire       isCtl    = inPage & (slot == `IIEP_SLOT_CTL);
	wire       isSum    = inPage & (slot == `IIEP_SLOT_SUMMARY);
	wire       isDbCtl  = inPage & (slot == `IIEP_SLOT_DBCTL);
	wire       isDbDur  = inPage & (slot == `IIEP_SLOT_DBDUR);
	wire       isDbClk  = inPage & (slot == `IIEP_SLOT_DBCLK);

	// mode and bank state
	iiep_pkg::iiep_mode_t mode_q;
	iiep_pkg::iiep_mode_t mode_d;
	logic [1:0] bank_q;
	logic [`IIEP_MASK_MSB:0] mask_q;
	wire enhanced = mode_q == iiep_pkg::MODE_ENH;
	wire [1:0] bankEff = enhanced ? bank_q : `IIEP_BANK_INPUT;
	wire inBank0 = bankEff == `IIEP_BANK_INPUT;
	wire inBank1 = bankEff == `IIEP_BANK_EVENT;
	wire inBank2 = bankEff == `IIEP_BANK_DEBOUNCE;

	// which locations answer in the current bank
	wire hitData = isData & (inBank0 | inBank1);
	wire hitSum  = isSum & inBank1;
	wire hitDb   = inBank2 & (isDbCtl | isDbDur | isDbClk);
	wire hit     = hitData | hitSum | hitDb | isCtl | isIrqEn;

	// write strobes per register
	wire wrCtl    = isWrite & isCtl;
	wire wrPort   = isWrite & isData & inBank0;
	wire wrEvent  = isWrite & isData & inBank1;
	wire wrPol    = isWrite & hitSum;
	wire wrDbCtl  = isWrite & inBank2 & isDbCtl;
	wire wrDbDur  = isWrite & inBank2 & isDbDur;
	wire wrDbClk  = isWrite & inBank2 & isDbClk;
	wire wrIrqEn  = isWrite & isIrqEn;
	wire [1:0] newBank = busReq.wdata[`IIEP_BANK_MSB:`IIEP_BANK_LSB];
	wire bankOk  = newBank != `IIEP_BANK_INVALID;

	// unlock sequence tracking
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			iiep_pkg::UNL_WAIT0: begin
				if (accStart) begin
					mode_d = (isWrite & isCtl & busReq.wdata == `IIEP_UNLOCK_B0) ?
						iiep_pkg::UNL_WAIT1 : iiep_pkg::MODE_STD;
				end
			end
			iiep_pkg::UNL_WAIT1: begin
				if (accStart) begin
					mode_d = (isWrite & isCtl & busReq.wdata == `IIEP_UNLOCK_B1) ?
						iiep_pkg::UNL_WAIT2 : iiep_pkg::MODE_STD;
				end
			end
			iiep_pkg::UNL_WAIT2: begin
				if (accStart) begin
					mode_d = (isWrite & isCtl & busReq.wdata == `IIEP_UNLOCK_B2) ?
						iiep_pkg::UNL_WAIT3 : iiep_pkg::MODE_STD;
				end
			end
			iiep_pkg::UNL_WAIT3: begin
				if (accStart) begin
					mode_d = (isWrite & isCtl & busReq.wdata == `IIEP_UNLOCK_B3) ?
						iiep_pkg::MODE_ENH : iiep_pkg::MODE_STD;
				end
			end
			iiep_pkg::MODE_ENH: mode_d = iiep_pkg::MODE_ENH;
			iiep_pkg::MODE_STD: mode_d = iiep_pkg::MODE_STD;
			default: mode_d = iiep_pkg::MODE_STD;
		endcase
	end

	// mode, mask and bank registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode_q <= iiep_pkg::UNL_WAIT0;
			mask_q <= `IIEP_MASK_RST;
			bank_q <= `IIEP_BANK_INPUT;
		end else begin
			mode_q <= mode_d;
			if (wrCtl) begin
				mask_q <= busReq.wdata[`IIEP_MASK_MSB:0];
			end
			if (wrCtl & enhanced & bankOk) begin
				bank_q <= newBank;
			end
		end
	end

	// per-port data registers and input read values
	logic [7:0] portReg_q [NUM_PORTS];
	logic [7:0] inRead [NUM_PORTS];
	logic [7:0] evRead [NUM_PORTS];
	logic [NUM_PORTS-1:0] portEvent;
	logic [LINES-1:0] eventFlags;
	logic [GROUPS-1:0] polarity_q;

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			// port select for this slot
			wire thisPort = slot == 3'(p);
			wire portWr   = wrPort & thisPort & ~mask_q[p];
			wire evWr     = wrEvent & thisPort;

			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					portReg_q[p] <= `IIEP_PORT_RST;
				end else if (portWr) begin
					portReg_q[p] <= busReq.wdata;
				end
			end

			// forced-off bits read as 0, bit 0 is lowest line
			assign inRead[p] = inputLines[p*LPP +: LPP] & ~portReg_q[p];
			assign evRead[p] = eventFlags[p*LPP +: LPP];
			assign portEvent[p] = |eventFlags[p*LPP +: LPP];

			genvar b;
			for (b = 0; b < LPP; b++) begin : g_line
				iiep_event_line u_line (
					.ref_clk   (ref_clk),
					.rst_n     (rst_n),
					.lineIn    (inputLines[p*LPP + b]),
					.fallSense (polarity_q[(p*LPP + b) / LPG]),
					.wrStb     (evWr),
					.wrBit     (busReq.wdata[b]),
					.eventFlag (eventFlags[p*LPP + b])
				);
			end
		end
	endgenerate

	// debounce, polarity and interrupt enable storage
	logic [7:0] dbCtl_q;
	logic [7:0] dbDur_q;
	logic       dbClk_q;
	logic       intEn_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			polarity_q <= '0;
			dbCtl_q    <= `IIEP_BYTE_RST;
			dbDur_q    <= `IIEP_BYTE_RST;
			dbClk_q    <= 1'b0;
			intEn_q    <= 1'b0;
		end else begin
			if (wrPol) begin
				polarity_q <= busReq.wdata[GROUPS-1:0];
			end
			if (wrDbCtl) begin
				dbCtl_q <= {4'h0, busReq.wdata[`IIEP_MASK_MSB:0]};
			end
			if (wrDbDur) begin
				dbDur_q <= busReq.wdata;
			end
			if (wrDbClk) begin
				dbClk_q <= busReq.wdata[0];
			end
			if (wrIrqEn) begin
				intEn_q <= busReq.wdata[`IIEP_IRQEN_BIT];
			end
		end
	end

	// summary status: per-port bits and any-event bit
	wire anyEvent = |portEvent;
	wire [7:0] sumRead = {anyEvent, 3'h0, 4'(portEvent)};
	wire [7:0] ctlRead = {bankEff, 2'h0, mask_q};
	wire [7:0] irqRead = {7'h00, intEn_q};

	// read data selection
	wire [7:0] dataRead = inBank1 ? evRead[slot[1:0]] : inRead[slot[1:0]];
	wire [7:0] dbRead   = isDbCtl ? dbCtl_q : (isDbDur ? dbDur_q : 8'h00);
	wire [7:0] rdMux =
		isIrqEn ? irqRead :
		isCtl   ? ctlRead :
		hitSum  ? sumRead :
		hitDb   ? dbRead  :
		dataRead;

	// bus answer, one cycle after the access starts
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			selPrev_q    <= 1'b0;
			busRsp.ack   <= 1'b0;
			busRsp.oe    <= 1'b0;
			busRsp.rdata <= 8'h00;
		end else begin
			selPrev_q    <= busReq.sel;
			busRsp.ack   <= accStart & hit;
			busRsp.oe    <= isRead & hit;
			busRsp.rdata <= (isRead & hit) ? rdMux : 8'h00;
		end
	end

	// interrupt request, active low
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			intReq0_n <= 1'b1;
		end else begin
			intReq0_n <= ~(intEn_q & anyEvent);
		end
	end

endmodule
`default_nettype wire

//--- dv/iiep_input_ports_assertions.sv
`default_nettype none
module iiep_input_ports_assertions #(
	parameter int NUM_PORTS = 4
) (
	input wire logic                    ref_clk,
	input wire logic                    rst_n,
	input wire iiep_pkg::iiep_bus_req_t busReq,
	input wire iiep_pkg::iiep_bus_rsp_t busRsp,
	input wire logic [NUM_PORTS*8-1:0]  inputLines,
	input wire logic                    intReq0_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic      sel_q;
	wire logic start = busReq.sel & ~sel_q;

	// previous select level, to spot access starts
	always_ff @(posedge ref_clk) begin
		sel_q <= rst_n & busReq.sel;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	chk_ack_has_start: assert property (busRsp.ack |-> $past(start))
		else $error("acknowledge without an access start");
	chk_ack_single: assert property (busRsp.ack |=> !busRsp.ack)
		else $error("acknowledge longer than one cycle");
	chk_oe_only_reads: assert property (busRsp.oe |-> busRsp.ack && !$past(busReq.write))
		else $error("data driven outside a read answer");
	chk_rdata_quiet: assert property (!busRsp.oe |-> busRsp.rdata == 8'h00)
		else $error("read data not quiet while undriven");
	chk_unused_silent: assert property (start && (busReq.addr inside {6'h04, 6'h05}
		|| busReq.addr > 6'h08) |=> !busRsp.ack && !busRsp.oe)
		else $error("answer to an unused location");
	chk_fixed_answer: assert property (start && busReq.addr inside {6'h07, 6'h08}
		|=> busRsp.ack && busRsp.oe == !$past(busReq.write))
		else $error("mapped access not answered next cycle");
	chk_ctl_unused_bits: assert property (busRsp.oe && $past(busReq.addr) == 6'h07
		|-> busRsp.rdata[5:4] == 2'h0)
		else $error("unused control bits read nonzero");
	chk_reset_quiet: assert property (disable iff (1'b0) !rst_n
		|=> intReq0_n && !busRsp.ack && !busRsp.oe)
		else $error("outputs active after reset edge");
endmodule
`default_nettype wire

//--- dv/iiep_carrier_bus.sv
`default_nettype none
module iiep_carrier_bus (
	input wire iiep_pkg::iiep_bus_rsp_t busRsp,
	output logic [15:0]                 hostData
);
	timeunit 1ns;
	timeprecision 1ns;
	// carrier pull-ups win wherever the module leaves the bus undriven
	assign hostData = {8'hFF, busRsp.oe ? busRsp.rdata : 8'hFF};
endmodule
`default_nettype wire

//--- dv/test_iiep_input_ports.sv
`default_nettype none
module test_iiep_input_ports;
	timeunit 1ns;
	timeprecision 1ns;
	logic                    ref_clk = 1'b0;
	logic                    rst_n = 1'b0;
	iiep_pkg::iiep_bus_req_t busReq = '0;
	iiep_pkg::iiep_bus_rsp_t busRsp;
	logic [31:0]             lines = 32'hA5C3_0F81;
	logic                    intReq0_n;
	logic [15:0]             hostData;
	int                      n_fail = 0;
	int                      samples_checked = 0;
	int                      cycles = 0;

	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;

	iiep_input_ports #(.NUM_PORTS(4)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq),
		.busRsp(busRsp), .inputLines(lines), .intReq0_n(intReq0_n));
	iiep_carrier_bus host (.busRsp(busRsp), .hostData(hostData));

	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// one byte cycle: select held until the clock edge after the answer edge, answer taken while it stands
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
			input logic ackE, input logic [7:0] e);
		logic [16:0] got;
		@(posedge ref_clk);
		busReq <= '{sel: 1'b1, write: w, addr: a, wdata: d};
		@(posedge ref_clk);
		@(negedge ref_clk);
		got = {busRsp.ack, hostData};
		@(posedge ref_clk);
		busReq.sel <= 1'b0;
		chk(got, {ackE, (ackE && !w) ? {8'hFF, e} : 16'hFFFF});
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		acc(1'b1, a, d, 1'b1, 8'h00);
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00, 1'b1, e);
	endtask

	task automatic nak(input logic w, input logic [5:0] a);
		acc(w, a, 8'h00, 1'b0, 8'h00);
	endtask

	// interrupt line level, looked at mid-cycle where it is settled
	task automatic chk_irq(input logic e);
		@(negedge ref_clk);
		chk({16'h0000, intReq0_n}, {16'h0000, e});
	endtask

	task automatic do_reset();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask

	// new line levels, then time for sampling and flag capture
	task automatic setL(input logic [31:0] v);
		@(posedge ref_clk);
		lines <= v;
		repeat (3) @(posedge ref_clk);
	endtask

	// cut a hang short
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			test_done();
		end
	end

	initial begin
		do_reset();
		// standard mode: reset values, line order, forced zeros, mask
		rd(6'h07, 8'h00);
		rd(6'h00, 8'h81);
		rd(6'h01, 8'h0F);
		rd(6'h02, 8'hC3);
		rd(6'h03, 8'hA5);
		nak(1'b0, 6'h04);
		nak(1'b1, 6'h05);
		nak(1'b0, 6'h06);
		nak(1'b0, 6'h09);
		wr(6'h00, 8'h0F);
		rd(6'h00, 8'h80);
		wr(6'h07, 8'h41);
		rd(6'h07, 8'h01);
		wr(6'h00, 8'h00);
		rd(6'h00, 8'h80);
		wr(6'h07, 8'h00);
		wr(6'h00, 8'h00);
		rd(6'h00, 8'h81);
		$display("test standard done");
		// a wrong byte abandons the unlock
		do_reset();
		wr(6'h07, 8'h07);
		wr(6'h07, 8'h0D);
		wr(6'h07, 8'h05);
		wr(6'h07, 8'h12);
		wr(6'h07, 8'h40);
		rd(6'h07, 8'h00);
		$display("test unlock refused done");
		// proper unlock, then events in bank 1
		do_reset();
		wr(6'h07, 8'h07);
		wr(6'h07, 8'h0D);
		wr(6'h07, 8'h06);
		wr(6'h07, 8'h12);
		rd(6'h07, 8'h02);
		wr(6'h07, 8'h40);
		rd(6'h07, 8'h40);
		wr(6'h06, 8'h00);
		wr(6'h00, 8'hFF);
		rd(6'h00, 8'h00);
		setL(32'hA5C3_0F83);
		rd(6'h00, 8'h02);
		rd(6'h06, 8'h81);
		chk_irq(1'b1);
		wr(6'h08, 8'h01);
		rd(6'h08, 8'h01);
		setL(32'hA5C3_0F81);
		rd(6'h00, 8'h02);
		chk_irq(1'b0);
		wr(6'h00, 8'hFD);
		rd(6'h00, 8'h00);
		chk_irq(1'b1);
		setL(32'hA5C3_0F83);
		rd(6'h00, 8'h00);
		wr(6'h06, 8'h01);
		wr(6'h00, 8'hFF);
		setL(32'hA5C3_0F81);
		rd(6'h00, 8'h02);
		$display("test events done");
		// bank codes: invalid write ignored, bank 2 map, back to bank 0
		wr(6'h07, 8'hC0);
		rd(6'h07, 8'h40);
		wr(6'h07, 8'h80);
		nak(1'b0, 6'h02);
		wr(6'h00, 8'hFF);
		rd(6'h00, 8'h0F);
		wr(6'h01, 8'h5A);
		rd(6'h01, 8'h5A);
		wr(6'h03, 8'h01);
		rd(6'h03, 8'h00);
		rd(6'h07, 8'h80);
		wr(6'h07, 8'h00);
		rd(6'h00, 8'h81);
		$display("test banks done");
		test_done();
	end
endmodule

bind iiep_input_ports iiep_input_ports_assertions #(.NUM_PORTS(NUM_PORTS)) asrt (
	.ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq), .busRsp(busRsp),
	.inputLines(inputLines), .intReq0_n(intReq0_n));
`default_nettype wire
